// ### verilog/rtccal_pkg.sv
// Constants shared by the calendar, trim and alarm register block
package rtccal_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADR_WEEKDAY = 4'h3;
  localparam logic [3:0] ADR_DATE = 4'h4;
  localparam logic [3:0] ADR_MONTH = 4'h5;
  localparam logic [3:0] ADR_YEAR = 4'h6;
  localparam logic [3:0] ADR_TRIM = 4'h7;
  localparam logic [3:0] ADR_WAMIN = 4'h8;
  localparam logic [3:0] ADR_WAHOUR = 4'h9;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int WEEKDAY_MSB = 2;
  localparam int DATE_MSB = 5;
  localparam int MONTH_MSB = 4;
  localparam int CENTURY_BIT = 7;
  localparam int TRIM_DIR_BIT = 6;
  localparam int TRIM_MAG_MSB = 5;
  localparam int WAMIN_MSB = 6;
  localparam int WAHOUR_MSB = 5;
  localparam int WAHOUR_PM_BIT = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] RST_WEEKDAY = 3'h0;
  localparam logic [5:0] RST_DATE = 6'h01;
  localparam logic [4:0] RST_MONTH = 5'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic RST_CENTURY = 1'b0;
  localparam logic [6:0] RST_TRIM = 7'h00;
  localparam logic [6:0] RST_WAMIN = 7'h00;
  localparam logic [5:0] RST_WAHOUR = 6'h00;
  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [15:0] SEC_CYCLES = 16'h8000;
endpackage : rtccal_pkg

// ### verilog/rtccal_trim_if.sv
// Carrier between the register block and the second prescaler
`timescale 1ns/100ps
`default_nettype none
interface rtccal_trim_if;
  logic osc_tick;
  logic trim_dir;
  logic [5:0] trim_mag;
  logic apply;
  logic sec_tick;
  modport ctl (
    output osc_tick,
    output trim_dir,
    output trim_mag,
    output apply,
    input sec_tick
  );
  modport trim (
    input osc_tick,
    input trim_dir,
    input trim_mag,
    input apply,
    output sec_tick
  );
endinterface : rtccal_trim_if
`default_nettype wire

// ### verilog/rtccal_sync.sv
// Two-stage synchroniser with rising edge pulse
`timescale 1ns/100ps
`default_nettype none
module rtccal_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rtccal_sync_st_t;
  rtccal_sync_st_t st_ff;
  rtccal_sync_st_t nxt_st;
  // Edge detect reads the second and third stages
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign rise = st_ff.s2 & ~st_ff.s3;
endmodule : rtccal_sync
`default_nettype wire

// ### verilog/rtccal_trim.sv
// Second prescaler with time-count trimming
`timescale 1ns/100ps
`default_nettype none
module rtccal_trim
  import rtccal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  rtccal_trim_if.trim tif
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } rtccal_trim_st_t;
  rtccal_trim_st_t st_ff;
  rtccal_trim_st_t nxt_st;
  logic [15:0] limit;
  // Period length; only the count is bent, the oscillator is untouched
  always_comb
  begin
    limit = SEC_CYCLES;
    if (tif.apply && (tif.trim_mag != 6'h00))
    begin
      if (!tif.trim_dir)
        limit = SEC_CYCLES + {9'h000, 6'(tif.trim_mag - 6'h01), 1'b0};
      else
        limit = SEC_CYCLES - {9'h000, 6'(~tif.trim_mag + 6'h01), 1'b0};
    end
  end
  // Count oscillator edges, pulse once per trimmed second
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (tif.osc_tick)
    begin
      if (st_ff.cnt == 16'(limit - 16'h0001))
      begin
        nxt_st.cnt = 16'h0000;
        nxt_st.tick = 1'b1;
      end
      else
        nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign tif.sec_tick = st_ff.tick;
  AST_SEC_PERIOD: assert property (@(posedge clk) disable iff (rst)
    tif.osc_tick && (st_ff.cnt == 16'(limit - 16'h0001)) |=> tif.sec_tick)
    else $error("second pulse missing at end of period");
endmodule : rtccal_trim
`default_nettype wire

// ### verilog/rtccal_top.sv
// Calendar counters, trim register and weekly alarm registers
// ****************************************
// ****************************************
`timescale 1ns/100ps
`default_nettype none
module rtccal_top
  import rtccal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_pin,
  input wire logic power_on_flag,
  input wire logic day_carry,
  input wire logic [7:0] sec_value,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic sec_tick,
  output logic [2:0] weekday,
  output logic [6:0] walarm_min,
  output logic [5:0] walarm_hour
);
  // ****************************************
  // State and helpers
  // ****************************************
  typedef struct packed {
    logic [2:0] wd;
    logic [5:0] date;
    logic cent;
    logic [4:0] mon;
    logic [7:0] yr;
    logic [6:0] trim;
    logic [6:0] wamin;
    logic [5:0] wahour;
    logic skip;
    logic [7:0] rdata;
  } rtccal_top_st_t;

  rtccal_top_st_t st_ff;
  rtccal_top_st_t nxt_st;
  rtccal_trim_if tif ();

  logic wr_wd;
  logic wr_date;
  logic wr_mon;
  logic wr_yr;
  logic wr_trim;
  logic wr_wamin;
  logic wr_wahour;
  logic leap;
  logic [7:0] last_day;
  logic date_carry;
  logic mon_carry;
  logic yr_carry;
  logic trim_slot;
  logic [7:0] rd_mux;

  // BCD increment of a packed two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9)
      r = {4'(v[7:4] + 4'h1), 4'h0};
    else
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    return r;
  endfunction : bcd_inc

  // ****************************************
  // Oscillator edge and second prescaler
  // ****************************************

  // Oscillator pin is asynchronous to clk, so it is synchronised first
  rtccal_sync u_osc_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(osc_pin),
    .rise(tif.osc_tick)
  );

  rtccal_trim u_trim (
    .clk(clk),
    .rst(rst),
    .tif(tif.trim)
  );

  // Trim window at 00, 20 and 40 seconds unless written this second
  assign trim_slot = (sec_value == 8'h00) || (sec_value == 8'h20) ||
                     (sec_value == 8'h40);
  assign tif.apply = trim_slot && !st_ff.skip && !wr_trim;
  assign tif.trim_dir = st_ff.trim[TRIM_DIR_BIT];
  assign tif.trim_mag = st_ff.trim[TRIM_MAG_MSB:0];

  // ****************************************
  // Write decode
  // ****************************************

  // One strobe per register
  assign wr_wd = reg_wr && (reg_addr == ADR_WEEKDAY);
  assign wr_date = reg_wr && (reg_addr == ADR_DATE);
  assign wr_mon = reg_wr && (reg_addr == ADR_MONTH);
  assign wr_yr = reg_wr && (reg_addr == ADR_YEAR);
  assign wr_trim = reg_wr && (reg_addr == ADR_TRIM);
  assign wr_wamin = reg_wr && (reg_addr == ADR_WAMIN);
  assign wr_wahour = reg_wr && (reg_addr == ADR_WAHOUR);

  // ****************************************
  // Calendar carry chain
  // ****************************************

  // Leap when BCD year is a multiple of four, year 00 included
  always_comb
  begin
    if (st_ff.yr[4])
      leap = (st_ff.yr[3:0] == 4'h2) || (st_ff.yr[3:0] == 4'h6);
    else
      leap = (st_ff.yr[3:0] == 4'h0) || (st_ff.yr[3:0] == 4'h4) ||
             (st_ff.yr[3:0] == 4'h8);
  end

  // Month length table
  always_comb
  begin
    case (st_ff.mon)
      5'h02: last_day = leap ? 8'h29 : 8'h28;
      5'h04: last_day = 8'h30;
      5'h06: last_day = 8'h30;
      5'h09: last_day = 8'h30;
      5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // Carries ripple through in the same cycle as the day carry
  assign date_carry = day_carry && ({2'b00, st_ff.date} == last_day);
  assign mon_carry = date_carry && (st_ff.mon == 5'h12);
  assign yr_carry = mon_carry && (st_ff.yr == 8'h99);

  // ****************************************
  // Next state
  // ****************************************

  // Host writes win over a carry landing in the same cycle; values that
  // do not exist are accepted as written and may count oddly afterwards
  always_comb
  begin
    nxt_st = st_ff;
    // Weekday, modulo seven
    if (wr_wd)
      nxt_st.wd = reg_wdata[WEEKDAY_MSB:0];
    else if (day_carry)
    begin
      if (st_ff.wd >= 3'h6)
        nxt_st.wd = 3'h0;
      else
        nxt_st.wd = 3'(st_ff.wd + 3'h1);
    end
    // Date
    if (wr_date)
      nxt_st.date = reg_wdata[DATE_MSB:0];
    else if (date_carry)
      nxt_st.date = 6'h01;
    else if (day_carry)
      nxt_st.date = 6'(bcd_inc({2'b00, st_ff.date}));
    // Month and century flag
    if (wr_mon)
    begin
      nxt_st.mon = reg_wdata[MONTH_MSB:0];
      nxt_st.cent = reg_wdata[CENTURY_BIT];
    end
    else
    begin
      if (mon_carry)
        nxt_st.mon = 5'h01;
      else if (date_carry)
        nxt_st.mon = 5'(bcd_inc({3'b000, st_ff.mon}));
      if (yr_carry)
        nxt_st.cent = ~st_ff.cent;
    end
    // Year
    if (wr_yr)
      nxt_st.yr = reg_wdata;
    else if (yr_carry)
      nxt_st.yr = 8'h00;
    else if (mon_carry)
      nxt_st.yr = bcd_inc(st_ff.yr);
    // Trim; top bit is never stored, power-on clear beats a write
    if (power_on_flag)
      nxt_st.trim = RST_TRIM;
    else if (wr_trim)
      nxt_st.trim = reg_wdata[6:0];
    // Skip marker: a write in the same cycle as the tick still counts
    if (wr_trim)
      nxt_st.skip = 1'b1;
    else if (tif.sec_tick)
      nxt_st.skip = 1'b0;
    // Weekly alarm minute and hour kept as written
    if (wr_wamin)
      nxt_st.wamin = reg_wdata[WAMIN_MSB:0];
    if (wr_wahour)
      nxt_st.wahour = reg_wdata[WAHOUR_MSB:0];
    // Read data captured on the read strobe
    if (reg_rd)
      nxt_st.rdata = rd_mux;
  end

  // ****************************************
  // Read mux
  // ****************************************

  // Unused and unmapped bits read as zero
  always_comb
  begin
    case (reg_addr)
      ADR_WEEKDAY: rd_mux = {5'h00, st_ff.wd};
      ADR_DATE: rd_mux = {2'b00, st_ff.date};
      ADR_MONTH: rd_mux = {st_ff.cent, 2'b00, st_ff.mon};
      ADR_YEAR: rd_mux = st_ff.yr;
      ADR_TRIM: rd_mux = {1'b0, st_ff.trim};
      ADR_WAMIN: rd_mux = {1'b0, st_ff.wamin};
      ADR_WAHOUR: rd_mux = {2'b00, st_ff.wahour};
      default: rd_mux = 8'h00;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************

  // Calendar comes up as day 0, 01-01-00, century 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff.wd <= RST_WEEKDAY;
      st_ff.date <= RST_DATE;
      st_ff.cent <= RST_CENTURY;
      st_ff.mon <= RST_MONTH;
      st_ff.yr <= RST_YEAR;
      st_ff.trim <= RST_TRIM;
      st_ff.wamin <= RST_WAMIN;
      st_ff.wahour <= RST_WAHOUR;
      st_ff.skip <= 1'b0;
      st_ff.rdata <= 8'h00;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Registered values feed the alarm comparator outside
  assign reg_rdata = st_ff.rdata;
  assign sec_tick = tif.sec_tick;
  assign weekday = st_ff.wd;
  assign walarm_min = st_ff.wamin;
  assign walarm_hour = st_ff.wahour;

  // ****************************************
  // Assertions
  // ****************************************

  AST_WEEKDAY_STEP: assert property (@(posedge clk) disable iff (rst)
    day_carry && !wr_wd && (st_ff.wd < 3'h6) |=>
    st_ff.wd == 3'($past(st_ff.wd) + 3'h1))
    else $error("weekday did not advance on day carry");

  AST_WEEKDAY_WRAP: assert property (@(posedge clk) disable iff (rst)
    day_carry && !wr_wd && (st_ff.wd == 3'h6) |=> st_ff.wd == 3'h0)
    else $error("weekday did not wrap after code six");

  AST_FEB_LEAP: assert property (@(posedge clk) disable iff (rst)
    day_carry && !reg_wr && leap && (st_ff.mon == 5'h02) &&
    (st_ff.date == 6'h28) |=> (st_ff.date == 6'h29) && (st_ff.mon == 5'h02))
    else $error("leap February ended at 28");

  AST_DATE_WRAP: assert property (@(posedge clk) disable iff (rst)
    day_carry && !reg_wr && ({2'b00, st_ff.date} == last_day) |=>
    (st_ff.date == 6'h01) && (st_ff.mon != $past(st_ff.mon)))
    else $error("date wrap did not carry into month");

  AST_MONTH_WRAP: assert property (@(posedge clk) disable iff (rst)
    mon_carry && !reg_wr && (st_ff.yr != 8'h99) |=>
    (st_ff.mon == 5'h01) && (st_ff.yr == bcd_inc($past(st_ff.yr))))
    else $error("december wrap did not step the year");

  AST_CENTURY: assert property (@(posedge clk) disable iff (rst)
    yr_carry && !reg_wr |=>
    (st_ff.yr == 8'h00) && (st_ff.cent != $past(st_ff.cent)))
    else $error("century flag not toggled at year wrap");

  AST_TRIM_CLEAR: assert property (@(posedge clk) disable iff (rst)
    power_on_flag |=> (st_ff.trim == 7'h00) && (reg_rdata[7] == 1'b0))
    else $error("trim not cleared by power-on flag");

  AST_TRIM_SKIP: assert property (@(posedge clk) disable iff (rst)
    wr_trim |=> !tif.apply)
    else $error("trim applied in the second it was written");

  AST_SKIP_HOLD: assert property (@(posedge clk) disable iff (rst)
    st_ff.skip && !tif.sec_tick |=> !tif.apply)
    else $error("trim applied before the written second ended");

  AST_TRIM_SLOT: assert property (@(posedge clk) disable iff (rst)
    !trim_slot |-> !tif.apply)
    else $error("trim applied outside seconds 00, 20 and 40");

  AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_trim && !power_on_flag |=> st_ff.trim == 7'($past(reg_wdata)))
    else $error("trim write not stored as written");

  AST_RESERVED_READ: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == ADR_WEEKDAY) |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved weekday bits read non-zero");
endmodule : rtccal_top
`default_nettype wire

// ### verification/rtccal_osc_model.sv
// Oscillator source standing in for the crystal beside the block
`timescale 1ns/100ps
`default_nettype none
module rtccal_osc_model #(
  parameter int HALF_NS = 75
) (
  output logic osc_pin
);
  // Free-running square wave, far faster than a real crystal so a second fits the run;
  // the offset keeps its edges away from the system clock edges
  initial
  begin
    osc_pin = 1'b0;
    #37;
    forever #HALF_NS osc_pin = ~osc_pin;
  end
endmodule : rtccal_osc_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the calendar, trim and alarm register block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rtccal_pkg::*;
;
  logic clk, rst, osc_pin, power_on_flag, day_carry, reg_wr, reg_rd, sec_tick;
  logic [7:0] sec_value, reg_wdata, reg_rdata, rd, mn, hr, tr;
  logic [3:0] reg_addr;
  logic [2:0] weekday;
  logic [6:0] walarm_min;
  logic [5:0] walarm_hour;
  logic [31:0] cal;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  time t1, t2;
  logic [31:0] corner [9] = '{32'h06310123, 32'h02300407, 32'h00280201, 32'h03280204,
    32'h05290200, 32'h01311299, 32'h04319299, 32'h00090919, 32'h00300919};
  logic [7:0] rstv [7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0] unmap [5] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'hF};

  rtccal_top u_dut (.clk(clk), .rst(rst), .osc_pin(osc_pin), .power_on_flag(power_on_flag),
    .day_carry(day_carry), .sec_value(sec_value), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_tick(sec_tick),
    .weekday(weekday), .walarm_min(walarm_min), .walarm_hour(walarm_hour));
  rtccal_osc_model #(.HALF_NS(50)) u_osc (.osc_pin(osc_pin));

  // System clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard: four seconds of about 65.6k cycles each must fit under it
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 280000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int bcd2i(logic [7:0] v);
    return int'(v[7:4]) * 10 + int'(v[3:0]);
  endfunction : bcd2i

  function automatic logic [7:0] i2b(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : i2b

  // Next calendar after a day carry, bytes weekday/date/month/year
  function automatic logic [31:0] nxt_cal(logic [31:0] c);
    int d, m, y, last;
    logic cen;
    logic [2:0] w;
    w = c[26:24];
    d = bcd2i(c[23:16]);
    cen = c[15];
    m = bcd2i({3'h0, c[12:8]});
    y = bcd2i(c[7:0]);
    last = (m == 2) ? ((y % 4 == 0) ? 29 : 28) : ((m inside {4, 6, 9, 11}) ? 30 : 31);
    w = (w == 3'h6) ? 3'h0 : w + 3'h1;
    d++;
    if (d > last)
    begin
      d = 1;
      m++;
      if (m > 12)
      begin
        m = 1;
        y = (y + 1) % 100;
        cen = (y == 0) ? ~cen : cen;
      end
    end
    return {5'h00, w, i2b(d), cen, 7'(i2b(m)), i2b(y)};
  endfunction : nxt_cal

  // Second length in oscillator edges
  function automatic logic [15:0] sec_len(logic [7:0] s, logic [7:0] t, logic skip);
    logic [5:0] inv;
    inv = ~t[5:0];
    if (skip || t[5:0] == 6'h00 || !(s inside {8'h00, 8'h20, 8'h40}))
      return SEC_CYCLES;
    if (t[6])
      return SEC_CYCLES - ((16'(inv) + 16'h0001) << 1);
    return SEC_CYCLES + ((16'(t[5:0]) - 16'h0001) << 1);
  endfunction : sec_len

  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_len(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_len

  task reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data is taken once it has settled after the strobe edge
  task reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask : reg_read

  // Load a calendar, fire one day carry, check every counter
  task cal_case(input logic [31:0] c);
    logic [31:0] e;
    e = nxt_cal(c);
    for (int i = 0; i < 4; i++)
      reg_write(4'(ADR_WEEKDAY + i), c[31 - 8 * i -: 8]);
    @(posedge clk);
    day_carry <= 1'b1;
    @(posedge clk);
    day_carry <= 1'b0;
    @(posedge clk);
    #1 chk_reg({5'h00, weekday}, e[31:24]);
    for (int i = 0; i < 4; i++)
    begin
      reg_read(4'(ADR_WEEKDAY + i), rd);
      chk_reg(rd, e[31 - 8 * i -: 8]);
    end
  endtask : cal_case

  // Step past the edge first so the pulse seen by the last call is not taken again
  task wait_tick(output time t);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (sec_tick !== 1'b1 && n < 200000)
    begin
      @(posedge clk);
      #1 n++;
    end
    t = $time;
    @(posedge clk);
  endtask : wait_tick

  task finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    power_on_flag = 1'b0;
    day_carry = 1'b0;
    sec_value = 8'h00;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    void'($urandom(58));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      reg_read(4'(ADR_WEEKDAY + i), rd);
      chk_reg(rd, rstv[i]);
    end
    foreach (unmap[i])
    begin
      reg_write(unmap[i], 8'h5A);
      reg_read(unmap[i], rd);
      chk_reg(rd, 8'h00);
    end
    // Stored registers with stray high bits; host keeps trim bit 7 clear
    for (int k = 0; k < 6; k++)
    begin
      mn = {1'b1, 3'($urandom_range(0, 5)), 4'($urandom_range(0, 9))};
      hr = {2'b11, 2'($urandom_range(0, 3)), 4'($urandom_range(0, 1))};
      tr = {1'b0, 7'($urandom)};
      reg_write(ADR_WAMIN, mn);
      reg_write(ADR_WAHOUR, hr);
      reg_write(ADR_TRIM, tr);
      reg_write(ADR_WEEKDAY, {5'h1F, 3'($urandom_range(0, 6))});
      reg_read(ADR_WAMIN, rd);
      chk_reg(rd, mn & 8'h7F);
      reg_read(ADR_WAHOUR, rd);
      chk_reg(rd, hr & 8'h3F);
      chk_reg({1'b0, walarm_min}, mn & 8'h7F);
      chk_reg({2'b00, walarm_hour}, hr & 8'h3F);
      reg_read(ADR_TRIM, rd);
      chk_reg(rd, tr);
      reg_read(ADR_WEEKDAY, rd);
      chk_reg(rd & 8'hF8, 8'h00);
    end
    reg_write(ADR_TRIM, 8'h55);
    @(posedge clk);
    power_on_flag <= 1'b1;
    @(posedge clk);
    power_on_flag <= 1'b0;
    reg_read(ADR_TRIM, rd);
    chk_reg(rd, 8'h00);
    // Only real dates are loaded, fixed corner dates first, then random late days
    foreach (corner[i])
      cal_case(corner[i]);
    for (int k = 0; k < 12; k++)
    begin
      cal = {8'($urandom_range(0, 6)), i2b($urandom_range(25, 28)),
        1'($urandom_range(0, 1)), 7'(i2b($urandom_range(1, 12))), i2b($urandom_range(0, 99))};
      cal_case(cal);
    end
    // Trimmed seconds, measured in oscillator edges of 100 ns
    reg_write(ADR_TRIM, 8'h7E);
    sec_value <= 8'h20;
    wait_tick(t1);
    wait_tick(t2);
    chk_len(16'((t2 - t1) / 100), sec_len(8'h20, 8'h7E, 1'b0));
    sec_value <= 8'h00;
    reg_write(ADR_TRIM, 8'h07);
    wait_tick(t1);
    chk_len(16'((t1 - t2) / 100), sec_len(8'h00, 8'h07, 1'b1));
    sec_value <= 8'h40;
    wait_tick(t2);
    chk_len(16'((t2 - t1) / 100), sec_len(8'h40, 8'h07, 1'b0));
    finish_test();
  end
endmodule : testbench
`default_nettype wire
